// [verilog/cps_pkg.sv]
// cps_pkg: constants and carriers for the program-space / stack / pointer block.
// assumes a single core clock and an instruction sequencer outside issuing one
// operation per request.
package cps_pkg;

   // program space
   localparam int          PC_W          = 15;
   localparam int          IMPL_W        = 12;            // 4096 implemented words
   localparam logic [14:0] IMPL_MASK     = 15'h0FFF;      // last implemented word
   localparam logic [14:0] RESET_VECTOR  = 15'h0000;
   localparam logic [14:0] IRQ_VECTOR    = 15'h0004;
   localparam int          WORD_W        = 14;
   localparam int          NUM_INSTR     = 48;

   // return stack
   localparam int          STK_DEPTH     = 16;
   localparam int          STK_PTR_W     = 5;
   localparam logic [4:0]  STK_FULL      = 5'h10;

   // pointers
   localparam int          PTR_W         = 16;
   localparam int          PROG_SEL_BIT  = 15;            // bit 7 of the high byte
   localparam int          DATA_ADDR_W   = 15;

   // register offsets on the plain register port
   localparam logic [3:0]  OFS_PTR0_LO   = 4'h0;
   localparam logic [3:0]  OFS_PTR0_HI   = 4'h1;
   localparam logic [3:0]  OFS_PTR1_LO   = 4'h2;
   localparam logic [3:0]  OFS_PTR1_HI   = 4'h3;
   localparam logic [3:0]  OFS_PCON      = 4'h4;
   localparam logic [3:0]  OFS_CTRL      = 4'h5;
   localparam logic [3:0]  OFS_IRQ_STAT  = 4'h6;
   localparam logic [3:0]  OFS_IRQ_MASK  = 4'h7;
   localparam logic [3:0]  OFS_PC_LO     = 4'h8;
   localparam logic [3:0]  OFS_PC_HI     = 4'h9;
   localparam logic [3:0]  OFS_STK_LVL   = 4'hA;

   // field positions
   localparam int          PCON_OVF_BIT  = 7;
   localparam int          PCON_UNF_BIT  = 6;
   localparam int          CTRL_STKRST_BIT = 0;
   localparam int          IRQ_OVF_BIT   = 0;
   localparam int          IRQ_UNF_BIT   = 1;
   localparam int          IRQ_PROG_BIT  = 2;

   // reset values
   localparam logic [7:0]  CTRL_RESET    = 8'h01;
   localparam logic [2:0]  MASK_RESET    = 3'h0;

   // operations issued by the sequencer
   typedef enum logic [3:0] {
      CPS_OP_NONE, CPS_OP_STEP, CPS_OP_JUMP, CPS_OP_CALL, CPS_OP_RETURN,
      CPS_OP_RETURN_WITH_LITERAL, CPS_OP_RETFIE, CPS_OP_IRQ, CPS_OP_BRW, CPS_OP_IND_RD,
      CPS_OP_IND_WR
   } cps_op_e;

   typedef enum logic {CPS_IDLE, CPS_FETCH_WAIT} cps_state_e;

   // request from the sequencer
   typedef struct packed {
      logic       valid;
      cps_op_e    op;
      logic [14:0] target;   // jump or call target
      logic [7:0] literal;   // literal for the literal return
      logic [7:0] wreg;      // working register value
      logic       ptr_sel;   // which pointer an indirect op uses
      logic [7:0] wdata;     // indirect write data
   } cps_req_s;

   // context that is shadowed on interrupt entry
   typedef struct packed {
      logic [7:0]  wreg;
      logic [4:0]  status;
      logic [4:0]  bank;
      logic [6:0]  pc_latch;
      logic [15:0] ptr0;
      logic [15:0] ptr1;
   } cps_ctx_s;

   // data-memory access toward the banked memory
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [14:0] addr;
      logic [7:0]  wdata;
   } cps_dmem_s;

endpackage

// [verilog/cps_core.sv]
// cps_core: program counter, return stack, indirect pointers, master clear
// handling and interrupt context shadowing of the core.
// assumes the sequencer issues one request at a time and waits while busy is
// high; flash answers a fetch in the same cycle as prog_rd.
//
// How it works
// R1: external reset pin enabled: master clear pin low resets the core.
// R2: external reset pin disabled: pin is a plain digital input only.
// R3: return stack holds sixteen entries of fifteen bits.
// R4: push on full sets overflow flag, pop on empty sets underflow flag.
// R5: with stack fault reset enabled, a stack fault resets the core.
// R6: interrupt entry saves context to shadows; interrupt return restores it.
// R7: two sixteen-bit pointers, each built from a high and low byte.
// R8: pointers reach data memory, program memory, and linear RAM; the code has no linear RAM view, only data and program memory.
// R9: indirect read of program memory takes one extra cycle.
// R10: fifteen-bit program counter over a 32K by 14 space.
// R11: addresses beyond 4096 words wrap inside implemented memory.
// R12: reset starts at 0000h; accepted interrupt goes to 0004h.
// R13: pointer high bit seven set makes indirect reads hit program memory.
// R14: indirect read of a program word returns its lower eight bits.
// R15: indirect writes aimed at program memory change nothing.
// R16: literal return pops the address and loads the literal into W.
// R17: sequencer decodes exactly 48 instructions; this block serves their flow ops.
// R18: pointer bit seven clear addresses data memory with remaining bits.
// R19: relative branch adds unsigned W to next address.
module cps_core
   import cps_pkg::*;
(
   // clock and reset
   input  wire logic              clock,
   input  wire logic              reset_n,
   // configuration and pin
   input  wire logic              ext_reset_pin_enable,
   input  wire logic              master_clear_pin,
   output logic                   master_clear_pin_digital_in,
   // sequencer request
   input  wire cps_pkg::cps_req_s req,
   input  wire cps_pkg::cps_ctx_s ctx_live,
   output logic                   busy,
   output logic [14:0]            pc,
   output logic [7:0]             wreg_load,
   output logic                   wreg_load_vld,
   output cps_pkg::cps_ctx_s      ctx_restore,
   output logic                   ctx_restore_vld,
   // program flash
   output logic                   prog_rd,
   output logic [11:0]            prog_addr,
   input  wire logic [13:0]       prog_rdata,
   // banked data memory
   output cps_pkg::cps_dmem_s     dmem,
   // register port
   input  wire logic [3:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [7:0]             reg_rdata,
   // interrupt and reset out
   output logic                   irq,
   output logic                   core_reset_n
);

   typedef struct packed {
      cps_state_e  state;
      logic [14:0] pc;
      logic [STK_DEPTH-1:0][14:0] stk;
      logic [4:0]  sp;
      logic        ovf;
      logic        unf;
      logic [1:0][15:0] ptr;
      logic [7:0]  ctrl;
      logic [2:0]  irq_stat;
      logic [2:0]  irq_mask;
      cps_ctx_s    shadow;
      logic [7:0]  wload;
      logic        wload_vld;
      logic        restore_vld;
      logic        prog_rd;
      cps_dmem_s   dmem;
      logic [7:0]  rdata;
      logic        soft_rst;
   } cps_state_s;

   cps_state_s st_reg;
   cps_state_s st_next;
   logic       rst_n_int;
   logic [14:0] next_pc;
   logic        push;
   logic        pop;
   logic        fault_ovf;
   logic        fault_unf;
   logic [15:0] sel_ptr;

   // pin acts as reset only when enabled; otherwise it is passed through
   assign rst_n_int       = reset_n & ~(ext_reset_pin_enable & ~master_clear_pin); // R1
   assign master_clear_pin_digital_in = ext_reset_pin_enable ? 1'b0 : master_clear_pin;       // R2

   // wrap the counter inside the implemented space
   assign next_pc = (st_reg.pc + 15'h0001) & IMPL_MASK; // R11

   assign sel_ptr   = st_reg.ptr[req.ptr_sel];
   assign push      = req.valid && !busy && (req.op == CPS_OP_CALL || req.op == CPS_OP_IRQ);
   assign pop       = req.valid && !busy &&
                      (req.op == CPS_OP_RETURN || req.op == CPS_OP_RETURN_WITH_LITERAL ||
                       req.op == CPS_OP_RETFIE);
   assign fault_ovf = push && st_reg.sp == STK_FULL;  // R4
   assign fault_unf = pop && st_reg.sp == 5'h00;      // R4

   // busy covers the extra fetch cycle of a program-memory indirect read
   assign busy = st_reg.state == CPS_FETCH_WAIT; // R9

   always_comb begin
      st_next             = st_reg;
      st_next.wload_vld   = 1'b0;
      st_next.restore_vld = 1'b0;
      st_next.prog_rd     = 1'b0;
      st_next.dmem.rd     = 1'b0;
      st_next.dmem.wr     = 1'b0;
      st_next.soft_rst    = 1'b0;

      unique case (st_reg.state)
         CPS_IDLE: begin
            if (req.valid) begin
               unique case (req.op) // R17
                  CPS_OP_NONE: begin
                  end
                  CPS_OP_STEP: st_next.pc = next_pc; // R10
                  CPS_OP_JUMP: st_next.pc = req.target & IMPL_MASK; // R11
                  CPS_OP_CALL, CPS_OP_IRQ: begin
                     if (!fault_ovf) begin
                        st_next.stk[st_reg.sp[3:0]] = next_pc; // R3
                        st_next.sp = st_reg.sp + 5'h01;
                     end else begin
                        st_next.ovf = 1'b1; // R4
                     end
                     if (req.op == CPS_OP_IRQ) begin
                        st_next.pc     = IRQ_VECTOR; // R12
                        st_next.shadow = ctx_live;   // R6
                     end else begin
                        st_next.pc = req.target & IMPL_MASK;
                     end
                  end
                  CPS_OP_RETURN, CPS_OP_RETURN_WITH_LITERAL, CPS_OP_RETFIE: begin
                     if (!fault_unf) begin
                        st_next.sp = st_reg.sp - 5'h01;
                        st_next.pc = st_reg.stk[st_next.sp[3:0]];
                     end else begin
                        st_next.unf = 1'b1; // R4
                     end
                     if (req.op == CPS_OP_RETURN_WITH_LITERAL) begin
                        st_next.wload     = req.literal; // R16
                        st_next.wload_vld = 1'b1;
                     end
                     if (req.op == CPS_OP_RETFIE) begin
                        st_next.restore_vld = 1'b1; // R6
                        st_next.ptr[0]      = st_reg.shadow.ptr0;
                        st_next.ptr[1]      = st_reg.shadow.ptr1;
                     end
                  end
                  CPS_OP_BRW: st_next.pc = (next_pc + {7'h00, req.wreg}) & IMPL_MASK; // R19
                  CPS_OP_IND_RD: begin
                     if (sel_ptr[PROG_SEL_BIT]) begin
                        st_next.prog_rd = 1'b1; // R13
                        st_next.state   = CPS_FETCH_WAIT; // R9
                     end else begin
                        st_next.dmem.rd   = 1'b1; // R18
                        st_next.dmem.addr = sel_ptr[DATA_ADDR_W-1:0]; // R8
                        st_next.pc        = next_pc;
                     end
                  end
                  CPS_OP_IND_WR: begin
                     // program memory is never written through a pointer
                     if (!sel_ptr[PROG_SEL_BIT]) begin // R15
                        st_next.dmem.wr    = 1'b1;
                        st_next.dmem.addr  = sel_ptr[DATA_ADDR_W-1:0];
                        st_next.dmem.wdata = req.wdata;
                     end
                     st_next.pc = next_pc;
                  end
                  default: begin
                  end
               endcase
            end
         end
         CPS_FETCH_WAIT: begin
            st_next.wload     = prog_rdata[7:0]; // R14
            st_next.wload_vld = 1'b1;
            st_next.pc        = next_pc;
            st_next.state     = CPS_IDLE;
         end
      endcase

      // stack fault reset request, gated by the control bit
      if ((fault_ovf || fault_unf) && st_reg.ctrl[CTRL_STKRST_BIT]) begin
         st_next.soft_rst = 1'b1; // R5
      end

      // register writes; pointers are assembled from byte halves
      if (reg_wr) begin
         unique case (reg_addr)
            OFS_PTR0_LO: st_next.ptr[0][7:0]  = reg_wdata; // R7
            OFS_PTR0_HI: st_next.ptr[0][15:8] = reg_wdata; // R7
            OFS_PTR1_LO: st_next.ptr[1][7:0]  = reg_wdata;
            OFS_PTR1_HI: st_next.ptr[1][15:8] = reg_wdata;
            OFS_PCON: begin
               // software clears, but a fault in the same cycle wins
               st_next.ovf = (st_reg.ovf & reg_wdata[PCON_OVF_BIT]) | fault_ovf;
               st_next.unf = (st_reg.unf & reg_wdata[PCON_UNF_BIT]) | fault_unf;
            end
            OFS_CTRL:     st_next.ctrl     = reg_wdata;
            OFS_IRQ_MASK: st_next.irq_mask = reg_wdata[2:0];
            default: begin
            end
         endcase
      end
      // read data, one cycle after the strobe
      st_next.rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            OFS_PTR0_LO:  st_next.rdata = st_reg.ptr[0][7:0];
            OFS_PTR0_HI:  st_next.rdata = st_reg.ptr[0][15:8];
            OFS_PTR1_LO:  st_next.rdata = st_reg.ptr[1][7:0];
            OFS_PTR1_HI:  st_next.rdata = st_reg.ptr[1][15:8];
            OFS_PCON:     st_next.rdata = {st_reg.ovf, st_reg.unf, 6'h00};
            OFS_CTRL:     st_next.rdata = st_reg.ctrl;
            OFS_IRQ_STAT: st_next.rdata = {5'h00, st_reg.irq_stat};
            OFS_IRQ_MASK: st_next.rdata = {5'h00, st_reg.irq_mask};
            OFS_PC_LO:    st_next.rdata = st_reg.pc[7:0];
            OFS_PC_HI:    st_next.rdata = {1'b0, st_reg.pc[14:8]};
            OFS_STK_LVL:  st_next.rdata = {3'h0, st_reg.sp};
            default:      st_next.rdata = 8'h00;
         endcase
      end

      // sticky event bits: a read clears, a new event in that cycle wins
      if (reg_rd && reg_addr == OFS_IRQ_STAT) begin
         st_next.irq_stat = 3'h0;
      end
      st_next.irq_stat[IRQ_OVF_BIT]  = st_next.irq_stat[IRQ_OVF_BIT]  | fault_ovf;
      st_next.irq_stat[IRQ_UNF_BIT]  = st_next.irq_stat[IRQ_UNF_BIT]  | fault_unf;
      st_next.irq_stat[IRQ_PROG_BIT] = st_next.irq_stat[IRQ_PROG_BIT] |
                                       (st_reg.state == CPS_FETCH_WAIT);
   end

   // the fault flags survive the soft reset so software can see the cause
   always_ff @(posedge clock or negedge rst_n_int) begin
      if (!rst_n_int) begin
         st_reg.state       <= CPS_IDLE;
         st_reg.pc          <= RESET_VECTOR; // R12
         st_reg.stk         <= '0;
         st_reg.sp          <= 5'h00;
         st_reg.ovf         <= 1'b0;
         st_reg.unf         <= 1'b0;
         st_reg.ptr         <= '0;
         st_reg.ctrl        <= CTRL_RESET;
         st_reg.irq_stat    <= 3'h0;
         st_reg.irq_mask    <= MASK_RESET;
         st_reg.shadow      <= '0;
         st_reg.wload       <= 8'h00;
         st_reg.wload_vld   <= 1'b0;
         st_reg.restore_vld <= 1'b0;
         st_reg.prog_rd     <= 1'b0;
         st_reg.dmem        <= '0;
         st_reg.rdata       <= 8'h00;
         st_reg.soft_rst    <= 1'b0;
      end else if (st_reg.soft_rst) begin
         st_reg.state     <= CPS_IDLE;
         st_reg.pc        <= RESET_VECTOR; // R5
         st_reg.sp        <= 5'h00;
         st_reg.soft_rst  <= 1'b0;
         st_reg.wload_vld <= 1'b0;
         st_reg.prog_rd   <= 1'b0;
         st_reg.dmem      <= '0;
         st_reg.rdata     <= st_next.rdata;
         st_reg.irq_stat  <= st_next.irq_stat;
         st_reg.ovf       <= st_next.ovf;
         st_reg.unf       <= st_next.unf;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs
   assign pc              = st_reg.pc;
   assign prog_rd         = st_reg.prog_rd;
   assign prog_addr       = st_reg.ptr[req.ptr_sel][IMPL_W-1:0]; // R11
   assign dmem            = st_reg.dmem;
   assign wreg_load       = st_reg.wload;
   assign wreg_load_vld   = st_reg.wload_vld;
   assign ctx_restore     = st_reg.shadow;
   assign ctx_restore_vld = st_reg.restore_vld;
   assign reg_rdata       = st_reg.rdata;
   assign irq             = |(st_reg.irq_stat & st_reg.irq_mask);
   assign core_reset_n    = rst_n_int & ~st_reg.soft_rst;

endmodule

// [verification/cps_flash_mdl.sv]
// cps_flash_mdl: program flash as seen by the core's indirect fetch port.
// assumes prog_addr is valid in the cycle of prog_rd; the model keeps it for the cycle after.
module cps_flash_mdl (
   // clock
   input  wire logic        clock,
   // fetch port
   input  wire logic        prog_rd,
   input  wire logic [11:0] prog_addr,
   output logic [13:0]      prog_rdata
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [11:0] addr_q;
   logic        hold_q;

   // remember the fetch so the answer stands one cycle after the strobe
   always_ff @(posedge clock) begin
      hold_q <= prog_rd;
      if (prog_rd) begin
         addr_q <= prog_addr;
      end
   end

   // words are a scramble of the address; outside the answer the bits are
   // inverted so a late sample cannot pass by luck
   always_comb begin
      if (prog_rd) begin
         prog_rdata = {2'b11, prog_addr ^ 12'hA5C};
      end else if (hold_q) begin
         prog_rdata = {2'b11, addr_q ^ 12'hA5C};
      end else begin
         prog_rdata = {2'b00, ~(addr_q ^ 12'hA5C)};
      end
   end
endmodule

// [verification/cps_core_chk.sv]
// cps_core_chk: port-level assertions for the program-space core.
// assumes it is bound to cps_core and sees only its ports.
module cps_core_chk
   import cps_pkg::*;
(
   // clock and reset
   input  wire logic              clock,
   input  wire logic              reset_n,
   // pin and reset out
   input  wire logic              ext_reset_pin_enable,
   input  wire logic              master_clear_pin,
   input  wire logic              master_clear_pin_digital_in,
   input  wire logic              core_reset_n,
   // sequencer side
   input  wire cps_pkg::cps_req_s req,
   input  wire logic              busy,
   input  wire logic [14:0]       pc,
   input  wire logic [7:0]        wreg_load,
   input  wire logic              wreg_load_vld,
   input  wire logic              ctx_restore_vld,
   input  wire logic              prog_rd
);
   timeunit 1ns;
   timeprecision 100ps;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   // a request only counts when the core is free to take it
   logic take;
   assign take = req.valid && !busy;

   // program fetch: busy with the strobe, then the load a cycle or two later
   sequence fetch_s;
      busy ##[1:2] wreg_load_vld;
   endsequence

   pin_digital_a: assert property (!ext_reset_pin_enable |-> master_clear_pin_digital_in == master_clear_pin)
      else $error("pin not passed through as digital input");
   pin_reset_a: assert property (ext_reset_pin_enable && !master_clear_pin |-> !core_reset_n)
      else $error("enabled pin low did not reset the core");
   soft_vector_a: assert property ($fell(core_reset_n) |-> ##[0:1] pc == RESET_VECTOR)
      else $error("reset did not return to the start vector");
   soft_pulse_a: assert property ($fell(core_reset_n) && master_clear_pin |=> core_reset_n)
      else $error("soft reset pulse longer than one cycle");
   irq_vector_a: assert property (take && req.op == CPS_OP_IRQ |=> pc == IRQ_VECTOR)
      else $error("interrupt entry missed its vector");
   jump_target_a: assert property (take && req.op == CPS_OP_JUMP
      |=> pc == ($past(req.target) & IMPL_MASK))
      else $error("jump did not load the target");
   branch_add_a: assert property (take && req.op == CPS_OP_BRW
      |=> pc == (($past(pc) + 15'h0001 + {7'h00, $past(req.wreg)}) & IMPL_MASK))
      else $error("branch by W landed wrong");
   return_with_literal_load_a: assert property (take && req.op == CPS_OP_RETURN_WITH_LITERAL
      |=> wreg_load_vld && wreg_load == $past(req.literal))
      else $error("literal return did not load W");
   ctx_restore_a: assert property (take && req.op == CPS_OP_RETFIE |=> ctx_restore_vld)
      else $error("context not restored on interrupt return");
   prog_fetch_a: assert property (prog_rd |-> fetch_s)
      else $error("program fetch without its extra cycle");
   ind_write_a: assert property (take && req.op == CPS_OP_IND_WR |=> !prog_rd && !busy)
      else $error("indirect write touched program memory");
endmodule

// [verification/testbench.sv]
// testbench: drives cps_core through its register port and sequencer port.
// assumes the flash model answers fetches; data memory is only observed.
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import cps_pkg::*;

   logic        clock, reset_n, ext_reset_pin_enable, master_clear_pin, master_clear_pin_digital_in;
   logic        busy, wreg_load_vld, ctx_restore_vld, prog_rd, reg_wr, reg_rd, irq;
   logic        core_reset_n;
   cps_req_s    req;
   cps_ctx_s    ctx_live, ctx_restore;
   cps_dmem_s   dmem;
   logic [14:0] pc;
   logic [13:0] prog_rdata;
   logic [11:0] prog_addr;
   logic [7:0]  wreg_load, reg_wdata, reg_rdata;
   logic [3:0]  reg_addr;
   int          num_errors, total_checks;

   cps_core dut (.clock, .reset_n, .ext_reset_pin_enable, .master_clear_pin, .master_clear_pin_digital_in,
      .req, .ctx_live, .busy, .pc, .wreg_load, .wreg_load_vld, .ctx_restore, .ctx_restore_vld,
      .prog_rd, .prog_addr, .prog_rdata, .dmem, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .irq, .core_reset_n);
   cps_flash_mdl u_flash (.clock, .prog_rd, .prog_addr, .prog_rdata);

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rc(input string n, input logic [3:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
      #1;
      chk(n, 16'(reg_rdata), 16'(e));
   endtask

   // w doubles as literal, write data and pointer select; e of 7FFF skips the pc check
   task automatic op(input cps_op_e o, input logic [14:0] t, input logic [7:0] w,
                     input logic [14:0] e);
      @(posedge clock);
      req.valid   <= 1'b1;
      req.op      <= o;
      req.target  <= t;
      req.wreg    <= w;
      req.literal <= w;
      req.wdata   <= w;
      req.ptr_sel <= w[0];
      @(posedge clock);
      req.valid   <= 1'b0;
      #1;
      if (e !== 15'h7FFF) begin
         chk("pc", 16'(pc), 16'(e));
      end
   endtask

   // bounded wait: 0 load pulse, 1 data read, 2 core reset
   task automatic wt(input int k);
      int n;
      for (n = 0; n < 8; n++) begin
         if ((k == 0 && wreg_load_vld === 1'b1) || (k == 1 && dmem.rd === 1'b1)
             || (k == 2 && core_reset_n === 1'b0)) begin
            break;
         end
         @(posedge clock);
         #1;
      end
      if (n == 8) begin
         num_errors++;
         test_done();
      end
   endtask

   initial begin
      int i;
      reset_n = 1'b0;
      ext_reset_pin_enable = 1'b0;
      master_clear_pin = 1'b1;
      req = '0;
      ctx_live = {8'h3C, 5'h15, 5'h0A, 7'h55, 16'h8123, 16'h1245};
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      num_errors = 0;
      total_checks = 0;
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      #1;
      chk("pc", 16'(pc), 16'(RESET_VECTOR));
      chk("pin in", 16'(master_clear_pin_digital_in), 16'h0001);
      rc("ctrl", OFS_CTRL, CTRL_RESET);
      rc("mask", OFS_IRQ_MASK, 8'h00);
      rc("unmapped", 4'hB, 8'h00);
      wr(OFS_CTRL, 8'h00);
      wr(OFS_IRQ_MASK, 8'h07);
      // pointers are built from independent byte halves
      wr(OFS_PTR0_LO, 8'h23);
      wr(OFS_PTR0_HI, 8'h81);
      wr(OFS_PTR1_HI, 8'h12);
      rc("ptr0 lo", OFS_PTR0_LO, 8'h23);
      rc("ptr0 hi", OFS_PTR0_HI, 8'h81);
      rc("ptr1 hi", OFS_PTR1_HI, 8'h12);
      // the last implemented word steps back into implemented space
      op(CPS_OP_JUMP, 15'h0FFF, 8'h00, 15'h0FFF);
      op(CPS_OP_STEP, 15'h0000, 8'h00, 15'h7FFF);
      chk("pc wrap", 16'(pc[11:0]), 16'h0000);
      op(CPS_OP_JUMP, 15'h0100, 8'h00, 15'h0100);
      op(CPS_OP_BRW, 15'h0000, 8'h05, 15'h0106);
      op(CPS_OP_BRW, 15'h0000, 8'hFF, 15'h0206);
      // fill all sixteen entries, then one push too many
      for (i = 0; i <= 16; i++) begin
         op(CPS_OP_CALL, 15'(i) + 15'h0300, 8'h00, 15'(i) + 15'h0300);
      end
      rc("level", OFS_STK_LVL, 8'h10);
      chk("irq", 16'(irq), 16'h0001);
      rc("status", OFS_PCON, 8'h80);
      rc("irq stat", OFS_IRQ_STAT, 8'h01);
      chk("irq", 16'(irq), 16'h0000);
      // unwind newest first; the oldest entry leaves by a literal return
      for (i = 0; i < 15; i++) begin
         op(CPS_OP_RETURN, 15'h0000, 8'h00, 15'h030F - 15'(i));
      end
      op(CPS_OP_RETURN_WITH_LITERAL, 15'h0000, 8'hC3, 15'h0207);
      chk("w load", 16'({wreg_load_vld, wreg_load}), 16'h01C3);
      op(CPS_OP_RETURN, 15'h0000, 8'h00, 15'h0207);
      rc("status", OFS_PCON, 8'hC0);
      wr(OFS_PCON, 8'h00);
      rc("status", OFS_PCON, 8'h00);
      rc("irq stat", OFS_IRQ_STAT, 8'h02);
      // with fault reset on, an empty pop restarts the core
      wr(OFS_CTRL, 8'h01);
      op(CPS_OP_RETURN, 15'h0000, 8'h00, 15'h7FFF);
      wt(2);
      @(posedge clock);
      #1;
      chk("pc", 16'(pc), 16'(RESET_VECTOR));
      // interrupt entry and return; shadows also reload both pointers
      op(CPS_OP_IRQ, 15'h0000, 8'h00, IRQ_VECTOR);
      op(CPS_OP_RETFIE, 15'h0000, 8'h00, 15'h7FFF);
      chk("ctx", 16'({ctx_restore_vld, ctx_restore.wreg}), 16'h013C);
      chk("ctx bank", 16'(ctx_restore.bank), 16'h000A);
      // program word through pointer 0, then a write that must not land
      op(CPS_OP_IND_RD, 15'h0000, 8'h00, 15'h7FFF);
      chk("busy", 16'(busy), 16'h0001);
      wt(0);
      chk("w load", 16'(wreg_load), 16'h007F);
      rc("irq stat", OFS_IRQ_STAT, 8'h06);
      op(CPS_OP_IND_WR, 15'h0000, 8'hAA, 15'h7FFF);
      for (i = 0; i < 3; i++) begin
         chk("no write", 16'({dmem.wr, prog_rd}), 16'h0000);
         @(posedge clock);
         #1;
      end
      op(CPS_OP_IND_RD, 15'h0000, 8'h01, 15'h7FFF);
      wt(1);
      chk("dmem addr", 16'(dmem.addr), 16'h1245);
      // odd w selects pointer 1, which aims at data memory, so this write lands
      op(CPS_OP_IND_WR, 15'h0000, 8'h5B, 15'h7FFF);
      chk("dmem wr", 16'({dmem.wr, dmem.wdata}), 16'h015B);
      chk("dmem wr addr", 16'(dmem.addr), 16'h1245);
      // the pin as a plain input, then as a reset
      @(posedge clock);
      master_clear_pin <= 1'b0;
      @(posedge clock);
      #1;
      chk("pin in", 16'({master_clear_pin_digital_in, core_reset_n}), 16'h0001);
      @(posedge clock);
      ext_reset_pin_enable <= 1'b1;
      @(posedge clock);
      #1;
      chk("pin reset", 16'({core_reset_n, pc}), 16'h0000);
      @(posedge clock);
      master_clear_pin <= 1'b1;
      @(posedge clock);
      test_done();
   end
endmodule

bind cps_core cps_core_chk u_chk (.clock(clock), .reset_n(reset_n),
   .ext_reset_pin_enable(ext_reset_pin_enable), .master_clear_pin(master_clear_pin),
   .master_clear_pin_digital_in(master_clear_pin_digital_in), .core_reset_n(core_reset_n), .req(req), .busy(busy),
   .pc(pc), .wreg_load(wreg_load), .wreg_load_vld(wreg_load_vld),
   .ctx_restore_vld(ctx_restore_vld), .prog_rd(prog_rd));
